/* rtl/bie_exec.sv */
// What this block does
// [RULE_01] PC writes except jump clear bit nine
// [RULE_02] I/O read-modify-write uses sampled pin levels
// [RULE_03] Direction load six copies acc to tristates
// [RULE_04] Result written to timer clears its prescaler
// [RULE_05] Add acc and file, select destination
// [RULE_06] Bit clear, flags untouched
// [RULE_07] Bit set, flags untouched
// [RULE_08] Literal AND into acc, zero flag only
// [RULE_09] File AND with acc, select destination
// [RULE_10] Skip next when tested bit is clear
// [RULE_11] Skipped instruction becomes no-operation
// [RULE_12] Zero, carry, nibble carry computed exactly
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`include "bie_map.svh"

module bie_exec (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [5:0]  AV_ADDRESS,
    input  wire logic        AV_READ,
    input  wire logic        AV_WRITE,
    input  wire logic [31:0] AV_WRITEDATA,
    input  wire logic [3:0]  AV_BYTEENABLE,
    output logic      [31:0] AV_READDATA,
    output logic             AV_WAITREQUEST,
    input  wire logic [7:0]  PORT_PIN_IN,
    output logic      [7:0]  PORT_OUT,
    output logic      [7:0]  PORT_OE
);
    import bie_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bie_bus_e    bus_state;
    logic [7:0]  acc;
    logic        flag_c;
    logic        flag_nov;
    logic        flag_z;
    logic [10:0] pc;
    logic        skip_pending;
    logic [11:0] last_instr;
    logic [7:0]  file_mem [32];
    logic [4:0]  file_idx;
    logic [7:0]  timer;
    logic [7:0]  prescale;
    logic        ps_assign;
    logic [7:0]  port_latch;
    logic [7:0]  dir_latch;
    logic [7:0]  pin_meta;
    logic [7:0]  pin_sync;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction : be_merge

    // Port reads return pins, not the latch, so read-modify-write sees the real level
    function automatic logic [7:0] file_rd(input logic [4:0] a);
        logic [7:0] v;
        v = file_mem[a];
        if (a == `BIE_FA_TIMER) begin
            v = timer;
        end else if (a == `BIE_FA_PCL) begin
            v = pc[7:0];
        end else if (a == `BIE_FA_STATUS) begin
            v = {5'h00, flag_z, flag_nov, flag_c};
        end else if (a == `BIE_FA_PORT) begin
            // [RULE_02] pins as source
            v = pin_sync;
        end
        return v;
    endfunction : file_rd

    // ------------------------------------------------------------
    // Avalon slave: one wait cycle per access
    // ------------------------------------------------------------
    logic acc_req;
    logic acc_done;
    logic wr_done;

    assign acc_req        = AV_READ | AV_WRITE;
    assign AV_WAITREQUEST = acc_req & (bus_state == BUS_IDLE);
    assign acc_done       = acc_req & (bus_state == BUS_ACK);
    assign wr_done        = acc_done & AV_WRITE;

    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (AV_ADDRESS)
            `BIE_REG_INSTR:     next_rdata = {20'h00000, last_instr};
            `BIE_REG_ACC:       next_rdata = {24'h000000, acc};
            `BIE_REG_FLAGS:     next_rdata = {29'h0, flag_z, flag_nov, flag_c};
            `BIE_REG_PC:        next_rdata = {21'h0, pc};
            `BIE_REG_DIR:       next_rdata = {24'h000000, dir_latch};
            `BIE_REG_PRESCALE:  next_rdata = {23'h0, ps_assign, prescale};
            `BIE_REG_FILE_IDX:  next_rdata = {27'h0, file_idx};
            `BIE_REG_FILE_DATA: next_rdata = {24'h000000, file_rd(file_idx)};
            `BIE_REG_SKIP:      next_rdata = {31'h0, skip_pending};
            default:            next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            bus_state   <= BUS_IDLE;
            AV_READDATA <= 32'h0000_0000;
        end else if (acc_req && bus_state == BUS_IDLE) begin
            bus_state   <= BUS_ACK;
            if (AV_READ) begin
                AV_READDATA <= next_rdata;
            end
        end else begin
            bus_state   <= BUS_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------
    logic [11:0] iw;
    logic        issue;
    bie_op_e     op;
    logic [4:0]  fa;
    logic [2:0]  bsel;
    logic [7:0]  fv;
    logic [8:0]  sum;
    logic [4:0]  nib;
    logic [7:0]  res;
    logic        wr_f;
    logic        wr_w;
    logic        upd_z;
    logic        upd_cy;
    logic        take_skip;

    assign iw    = AV_WRITEDATA[11:0];
    assign issue = wr_done && AV_ADDRESS == `BIE_REG_INSTR && AV_BYTEENABLE[1:0] == 2'h3;
    assign fa    = iw[4:0];
    assign bsel  = iw[7:5];
    assign sum   = {1'b0, acc} + {1'b0, fv};
    assign nib   = {1'b0, acc[3:0]} + {1'b0, fv[3:0]};

    // Combinational process so the operand follows every state it reads
    always_comb begin
        fv = file_rd(fa);
    end

    always_comb begin
        // [RULE_11] discarded slot runs as no-operation
        op        = skip_pending ? OP_NOP : bie_decode(iw);
        res       = 8'h00;
        wr_f      = 1'b0;
        wr_w      = 1'b0;
        upd_z     = 1'b0;
        upd_cy    = 1'b0;
        take_skip = 1'b0;
        unique case (op)
            OP_ADD: begin
                // [RULE_05] add with destination
                res    = sum[7:0];
                wr_f   = iw[5];
                wr_w   = ~iw[5];
                upd_z  = 1'b1;
                upd_cy = 1'b1;
            end
            OP_ANDF: begin
                // [RULE_09] file AND with destination
                res   = acc & fv;
                wr_f  = iw[5];
                wr_w  = ~iw[5];
                upd_z = 1'b1;
            end
            OP_ANDL: begin
                // [RULE_08] literal AND into acc
                res   = acc & iw[7:0];
                wr_w  = 1'b1;
                upd_z = 1'b1;
            end
            OP_BCLR: begin
                // [RULE_06] clear selected bit
                res       = fv;
                res[bsel] = 1'b0;
                wr_f      = 1'b1;
            end
            OP_BSET: begin
                // [RULE_07] set selected bit
                res       = fv;
                res[bsel] = 1'b1;
                wr_f      = 1'b1;
            end
            OP_BTSC: begin
                // [RULE_10] skip when bit clear
                take_skip = ~fv[bsel];
            end
            OP_JUMP: begin
                // The fetched follower is discarded, making the jump two cycles
                take_skip = 1'b1;
            end
            OP_DIR, OP_NOP: begin
                res = 8'h00;
            end
        endcase
    end

    logic do_wf;
    logic do_ww;

    assign do_wf = issue & wr_f;
    assign do_ww = issue & wr_w;

    // ------------------------------------------------------------
    // Accumulator and flags
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            acc <= `BIE_RST_ACC;
        end else if (do_ww) begin
            acc <= res;
        end else if (wr_done && AV_ADDRESS == `BIE_REG_ACC && AV_BYTEENABLE[0]) begin
            acc <= AV_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            flag_c   <= 1'b0;
            flag_nov <= 1'b0;
            flag_z   <= 1'b0;
        end else if (issue && (upd_z || upd_cy)) begin
            // [RULE_12] exact flag values
            flag_z <= (res == 8'h00);
            if (upd_cy) begin
                flag_c   <= sum[8];
                flag_nov <= nib[4];
            end
        end else if (do_wf && fa == `BIE_FA_STATUS) begin
            {flag_z, flag_nov, flag_c} <= res[2:0];
        end else if (wr_done && AV_ADDRESS == `BIE_REG_FLAGS && AV_BYTEENABLE[0]) begin
            {flag_z, flag_nov, flag_c} <= AV_WRITEDATA[2:0];
        end
    end

    // ------------------------------------------------------------
    // Program counter and skip
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pc           <= `BIE_RST_PC;
            skip_pending <= 1'b0;
            last_instr   <= 12'h000;
        end else if (issue) begin
            last_instr   <= iw;
            skip_pending <= take_skip;
            if (op == OP_JUMP) begin
                pc[8:0] <= iw[8:0];
            end else if (do_wf && fa == `BIE_FA_PCL) begin
                // [RULE_01] bit nine forced low
                pc[7:0]                <= res;
                pc[8]                  <= 1'b0;
                pc[`BIE_PC_KEEP_ZERO]  <= 1'b0;
            end else begin
                pc <= pc + 11'h001;
            end
        end else if (wr_done && AV_ADDRESS == `BIE_REG_PC) begin
            pc <= 11'(be_merge({21'h0, pc}, AV_WRITEDATA, AV_BYTEENABLE));
        end
    end

    // ------------------------------------------------------------
    // File registers, timer and prescaler
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            file_idx <= 5'h00;
        end else if (wr_done && AV_ADDRESS == `BIE_REG_FILE_IDX && AV_BYTEENABLE[0]) begin
            file_idx <= AV_WRITEDATA[4:0];
        end
    end

    logic host_fw;

    assign host_fw = wr_done && AV_ADDRESS == `BIE_REG_FILE_DATA && AV_BYTEENABLE[0];

    // Plain file storage has no reset; software initialises what it uses
    always_ff @(posedge CLK) begin
        if (do_wf) begin
            file_mem[fa] <= res;
        end else if (host_fw) begin
            file_mem[file_idx] <= AV_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            timer     <= 8'h00;
            prescale  <= 8'h00;
            ps_assign <= `BIE_RST_PS_ASSIGN;
        end else begin
            if (do_wf && fa == `BIE_FA_TIMER) begin
                timer <= res;
            end else if (host_fw && file_idx == `BIE_FA_TIMER) begin
                timer <= AV_WRITEDATA[7:0];
            end else if (ps_assign && prescale == 8'hff) begin
                timer <= timer + 8'h01;
            end
            // [RULE_04] timer write clears prescaler
            if (do_wf && fa == `BIE_FA_TIMER && ps_assign) begin
                prescale <= 8'h00;
            end else begin
                prescale <= prescale + 8'h01;
            end
            if (wr_done && AV_ADDRESS == `BIE_REG_PRESCALE && AV_BYTEENABLE[1]) begin
                ps_assign <= AV_WRITEDATA[`BIE_PS_ASSIGN];
            end
        end
    end

    // ------------------------------------------------------------
    // First I/O port
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= PORT_PIN_IN;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            port_latch <= `BIE_RST_PORT;
        end else if (do_wf && fa == `BIE_FA_PORT) begin
            port_latch <= res;
        end else if (host_fw && file_idx == `BIE_FA_PORT) begin
            port_latch <= AV_WRITEDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            dir_latch <= `BIE_RST_DIR;
        end else if (issue && op == OP_DIR && iw[2:0] == `BIE_DIR_OPERAND) begin
            // [RULE_03] acc into tristate latches
            dir_latch <= acc;
        end
    end

    // A one in the direction latch floats the pin
    assign PORT_OUT = port_latch;
    assign PORT_OE  = ~dir_latch;

endmodule : bie_exec

/* shared/bie_map.svh */
`ifndef BIE_MAP_SVH
`define BIE_MAP_SVH

// ------------------------------------------------------------
// Bus register byte addresses
// ------------------------------------------------------------
`define BIE_REG_INSTR      6'h00
`define BIE_REG_ACC        6'h04
`define BIE_REG_FLAGS      6'h08
`define BIE_REG_PC         6'h0c
`define BIE_REG_DIR        6'h10
`define BIE_REG_PRESCALE   6'h14
`define BIE_REG_FILE_IDX   6'h18
`define BIE_REG_FILE_DATA  6'h1c
`define BIE_REG_SKIP       6'h20

// ------------------------------------------------------------
// Fields and file addresses
// ------------------------------------------------------------
`define BIE_FLAG_C         0
`define BIE_FLAG_NOV       1
`define BIE_FLAG_Z         2
`define BIE_PS_ASSIGN      8
`define BIE_PC_KEEP_ZERO   9
`define BIE_FA_TIMER       5'h01
`define BIE_FA_PCL         5'h02
`define BIE_FA_STATUS      5'h03
`define BIE_FA_PORT        5'h06
`define BIE_DIR_OPERAND    3'h6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BIE_RST_ACC        8'h00
`define BIE_RST_PC         11'h000
`define BIE_RST_DIR        8'hff
`define BIE_RST_PORT       8'h00
`define BIE_RST_PS_ASSIGN  1'b1

`endif

/* shared/bie_pkg.sv */
package bie_pkg;

    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_ADD  = 4'h1,
        OP_ANDF = 4'h2,
        OP_ANDL = 4'h3,
        OP_BCLR = 4'h4,
        OP_BSET = 4'h5,
        OP_BTSC = 4'h6,
        OP_JUMP = 4'h7,
        OP_DIR  = 4'h8
    } bie_op_e;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bie_bus_e;

    // Anything outside the covered subset executes as a no-operation
    function automatic bie_op_e bie_decode(input logic [11:0] iw);
        bie_op_e op;
        op = OP_NOP;
        if (iw[11:6] == 6'h07) begin
            op = OP_ADD;
        end else if (iw[11:6] == 6'h05) begin
            op = OP_ANDF;
        end else if (iw[11:8] == 4'he) begin
            op = OP_ANDL;
        end else if (iw[11:8] == 4'h4) begin
            op = OP_BCLR;
        end else if (iw[11:8] == 4'h5) begin
            op = OP_BSET;
        end else if (iw[11:8] == 4'h6) begin
            op = OP_BTSC;
        end else if (iw[11:9] == 3'h5) begin
            op = OP_JUMP;
        end else if (iw[11:3] == 9'h000 && iw[2:0] != 3'h0) begin
            op = OP_DIR;
        end
        return op;
    endfunction : bie_decode

endpackage : bie_pkg

/* tb/bie_exec_props.sv */
module bie_exec_chk (
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic [5:0]  AV_ADDRESS,
    input wire logic        AV_READ,
    input wire logic        AV_WRITE,
    input wire logic [31:0] AV_WRITEDATA,
    input wire logic [3:0]  AV_BYTEENABLE,
    input wire logic [31:0] AV_READDATA,
    input wire logic        AV_WAITREQUEST,
    input wire logic [7:0]  PORT_PIN_IN,
    input wire logic [7:0]  PORT_OUT,
    input wire logic [7:0]  PORT_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    a_wait_new_req: assert property (((AV_READ || AV_WRITE) && !$past(AV_READ || AV_WRITE)) |-> AV_WAITREQUEST)
        else $error("new request not held off");
    a_one_wait: assert property (((AV_READ || AV_WRITE) && AV_WAITREQUEST) |=> !AV_WAITREQUEST)
        else $error("more than one wait cycle");
    a_idle_no_wait: assert property (!(AV_READ || AV_WRITE) |-> !AV_WAITREQUEST)
        else $error("wait raised while idle");
    a_rdata_hold: assert property ($changed(AV_READDATA) |-> $past(AV_READ && AV_WAITREQUEST))
        else $error("read data moved outside a read");
    a_unmapped_zero: assert property ((AV_READ && !AV_WAITREQUEST && AV_ADDRESS > 6'h20) |-> AV_READDATA == 32'h0)
        else $error("unmapped read not zero");
    a_dir_view: assert property ((AV_READ && !AV_WAITREQUEST && AV_ADDRESS == 6'h10)
        |-> AV_READDATA == {24'h0, ~PORT_OE}) else $error("direction view disagrees with enables");
    a_oe_dir_load: assert property ($changed(PORT_OE)
        |-> $past(AV_WRITE && !AV_WAITREQUEST && AV_ADDRESS == 6'h00 && AV_WRITEDATA[11:0] == 12'h006))
        else $error("enables moved without direction load six");
    a_out_on_write: assert property ($changed(PORT_OUT)
        |-> $past(AV_WRITE && !AV_WAITREQUEST && (AV_ADDRESS == 6'h00 || AV_ADDRESS == 6'h1c)))
        else $error("port latch moved without a write");
endmodule : bie_exec_chk

bind bie_exec bie_exec_chk u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .AV_ADDRESS(AV_ADDRESS), .AV_READ(AV_READ),
    .AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA), .AV_BYTEENABLE(AV_BYTEENABLE), .AV_READDATA(AV_READDATA),
    .AV_WAITREQUEST(AV_WAITREQUEST), .PORT_PIN_IN(PORT_PIN_IN), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));

/* tb/bie_exec_tb.sv */
module bie_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        sys_rst;
    logic [5:0]  av_address;
    logic        av_read;
    logic        av_write;
    logic [31:0] av_writedata;
    logic [31:0] av_readdata;
    logic        av_waitrequest;
    logic [7:0]  port_pin_in;
    logic [7:0]  port_out;
    logic [7:0]  port_oe;
    int          err_total;
    int          num_checks;

    bie_exec dut_u (.CLK(clk), .SYS_RST(sys_rst), .AV_ADDRESS(av_address), .AV_READ(av_read),
        .AV_WRITE(av_write), .AV_WRITEDATA(av_writedata), .AV_BYTEENABLE(4'hf), .AV_READDATA(av_readdata),
        .AV_WAITREQUEST(av_waitrequest), .PORT_PIN_IN(port_pin_in), .PORT_OUT(port_out), .PORT_OE(port_oe));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until waitrequest is seen low; one idle edge follows release
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        av_address <= a;
        av_writedata <= d;
        av_write <= w;
        av_read <= ~w;
        // Only the watchdog ends a wait that never finishes
        do begin
            @(posedge clk);
        end while (av_waitrequest !== 1'b0);
        q = av_readdata;
        av_write <= 1'b0;
        av_read <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic ex(input logic [11:0] iw);
        wr(6'h00, {20'h0, iw});
    endtask : ex

    task automatic rc(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask : rc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        chk(port_oe, 8'h00);
        rc(6'h10, 32'hff);
        bus(1'b0, 6'h14, 32'h0, q);
        chk(q[8], 1'b1);
        wr(6'h24, 32'hffff);
        rc(6'h24, 32'h0);
    endtask : t_reset

    task automatic t_add();
        wr(6'h04, 32'h0f);
        wr(6'h18, 32'h08);
        wr(6'h1c, 32'hf1);
        ex(12'h1c8);
        rc(6'h04, 32'h00);
        rc(6'h08, 32'h7);
        wr(6'h04, 32'h03);
        wr(6'h1c, 32'h04);
        ex(12'h1e8);
        rc(6'h1c, 32'h07);
        rc(6'h04, 32'h03);
        rc(6'h08, 32'h0);
        wr(6'h04, 32'h08);
        wr(6'h1c, 32'h08);
        ex(12'h1c8);
        rc(6'h04, 32'h10);
        rc(6'h08, 32'h2);
    endtask : t_add

    task automatic t_and();
        wr(6'h08, 32'h3);
        wr(6'h04, 32'ha5);
        ex(12'he5a);
        rc(6'h04, 32'h00);
        rc(6'h08, 32'h7);
        wr(6'h04, 32'hf0);
        wr(6'h1c, 32'h3c);
        ex(12'h168);
        rc(6'h1c, 32'h30);
        rc(6'h04, 32'hf0);
        rc(6'h08, 32'h3);
        ex(12'h148);
        rc(6'h04, 32'h30);
    endtask : t_and

    task automatic t_bits();
        wr(6'h1c, 32'h00);
        wr(6'h08, 32'h5);
        for (int b = 0; b < 8; b++) begin
            ex(12'h508 | 12'(b << 5));
            rc(6'h1c, 32'((2 << b) - 1));
        end
        for (int b = 0; b < 8; b++) begin
            ex(12'h408 | 12'(b << 5));
            rc(6'h1c, 32'((32'hff << (b + 1)) & 32'hff));
        end
        rc(6'h08, 32'h5);
    endtask : t_bits

    task automatic t_skip();
        wr(6'h1c, 32'hf7);
        wr(6'h04, 32'h55);
        wr(6'h0c, 32'h0);
        wr(6'h08, 32'h3);
        ex(12'h668);
        rc(6'h20, 32'h1);
        ex(12'he00);
        rc(6'h04, 32'h55);
        rc(6'h0c, 32'h2);
        ex(12'h648);
        rc(6'h20, 32'h0);
        ex(12'he0f);
        rc(6'h04, 32'h05);
        rc(6'h08, 32'h3);
    endtask : t_skip

    task automatic t_pc();
        wr(6'h0c, 32'h310);
        wr(6'h04, 32'h01);
        ex(12'h1e2);
        rc(6'h0c, 32'h011);
        wr(6'h0c, 32'h600);
        ex(12'hbff);
        rc(6'h0c, 32'h7ff);
        ex(12'h000);
    endtask : t_pc

    task automatic t_port();
        port_pin_in <= 8'h0f;
        wr(6'h18, 32'h06);
        wr(6'h1c, 32'hf0);
        chk(port_out, 8'hf0);
        ex(12'h5e6);
        chk(port_out, 8'h8f);
        wr(6'h04, 32'h3c);
        ex(12'h006);
        chk(port_oe, 8'hc3);
        rc(6'h10, 32'h3c);
        ex(12'h005);
        chk(port_oe, 8'hc3);
    endtask : t_port

    // First add clears the prescaler so the timer cannot tick during the test
    task automatic t_timer();
        logic [31:0] q;
        wr(6'h18, 32'h01);
        wr(6'h04, 32'h00);
        ex(12'h1e1);
        wr(6'h1c, 32'h20);
        wr(6'h04, 32'h10);
        ex(12'h1e1);
        bus(1'b0, 6'h14, 32'h0, q);
        chk(q[7:0] >> 2, 8'h0);
        rc(6'h1c, 32'h30);
    endtask : t_timer

    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        av_address = 6'h00;
        av_read = 1'b0;
        av_write = 1'b0;
        av_writedata = 32'h0;
        port_pin_in = 8'h00;
        err_total = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_add();
        t_and();
        t_bits();
        t_skip();
        t_pc();
        t_port();
        t_timer();
        finish_test();
    end
endmodule : bie_exec_tb
